// ---- adc_conversion_control.sv ----
// Converter control: registers, triggers, sleep handling, sequencer
//
// Function
// - With RC clock selected, start is delayed one instruction cycle.
// - Enabled done interrupt during sleep wakes the device at completion.
// - Done interrupt masked in sleep: converter powers down, enable stays set.
// - External trigger in sleep with RC clock converts and sets done flag.
// - External trigger in sleep on other clock is latched until wake.
// - Rising edge of selected auto trigger source sets the go bit.
// - Five-bit field in trigger register selects the auto trigger source.
// - Control bit 7 enables the converter when 1, disables when 0.
// - Five-bit extra capacitor field adds 1 pF per step, up to 31 pF.
// - Eight-bit repeat threshold holds the trigger count compare value.
// - Threshold check fires when trigger count reaches repeat threshold.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_conv_consts.svh"

module adc_conversion_control
  import adc_conv_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     clkEn,
  input  wire logic [3:0]               regAddr,
  input  wire logic [7:0]               regWrData,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic      [7:0]               regRdData_q,
  input  wire logic                     sleepActive,
  input  wire logic                     extTrigger,
  input  wire logic [31:0]              autoTrigSources,
  input  wire logic                     rcClockTick,
  input  wire logic                     convDone,
  input  wire logic [`RESULT_WIDTH-1:0] convData,
  output logic                          convStart_q,
  output logic                          convClockTick_q,
  output logic                          convPowered_q,
  output logic [`SEL_WIDTH-1:0]         extraSampleCap_q,
  output logic                          wakeRequest_q,
  output logic                          irq_q
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Result formatting; used for both current and previous result
  function automatic logic [15:0] formatResult(
    input logic [`RESULT_WIDTH-1:0] value,
    input logic                     rightJustify
  );
    if (rightJustify) begin
      formatResult = {6'h00, value};
    end else begin
      formatResult = {value, 6'h00};
    end
  endfunction : formatResult

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic                        convEnable_q;
  logic                        continuousEnable_q;
  logic                        convClockSelect_q;
  logic                        resultJustify_q;
  logic                        convGo_q;
  logic                        convGo_d;
  logic [`SEL_WIDTH-1:0]       autoTrigSource_q;
  logic [7:0]                  repeatThreshold_q;
  logic [5:0]                  clockDivider_q;
  logic [7:0]                  triggerCount_q;
  logic [7:0]                  triggerCount_d;
  logic [`RESULT_WIDTH-1:0]    convResult_q;
  logic [`RESULT_WIDTH-1:0]    previousResult_q;
  logic [`STAT_BITS-1:0]       status_q;
  logic [`STAT_BITS-1:0]       status_d;
  logic [`STAT_BITS-1:0]       mask_q;
  logic                        autoPrev_q;
  logic                        extPrev_q;
  logic                        powerDown_q;
  logic                        powerDown_d;
  conv_state_e                 state_q;
  conv_state_e                 state_d;
  logic [2:0]                  delayCount_q;
  logic [2:0]                  delayCount_d;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire wrCtrl0  = regWr && (regAddr == `OFS_CTRL0);
  wire wrCap    = regWr && (regAddr == `OFS_EXTRA_CAP);
  wire wrRpt    = regWr && (regAddr == `OFS_REPEAT_THR);
  wire wrTrig   = regWr && (regAddr == `OFS_TRIG_SEL);
  wire wrClkDiv = regWr && (regAddr == `OFS_CLK_DIV);
  wire wrMask   = regWr && (regAddr == `OFS_MASK);
  wire rdStatus = regRd && (regAddr == `OFS_STATUS);

  // ----------------------------------------------------------------
  // Trigger detection
  // ----------------------------------------------------------------
  wire autoSelected = autoTrigSources[autoTrigSource_q];
  wire autoRise     = autoSelected && !autoPrev_q;
  wire extRise      = extTrigger && !extPrev_q;
  wire hwTrigger    = convEnable_q && (autoRise || extRise);
  wire swGoSet      = wrCtrl0 && regWrData[`CTRL0_GO];
  wire swGoClear    = wrCtrl0 && !regWrData[`CTRL0_GO];

  // ----------------------------------------------------------------
  // Start qualification
  // ----------------------------------------------------------------
  // A divided system clock stops in sleep, so a go set then (an
  // external trigger included) simply waits in the go bit for wake.
  wire sleepBlocks  = sleepActive && !convClockSelect_q;
  wire startAllowed = convEnable_q && !sleepBlocks
                      && !powerDown_q;
  wire isIdle       = (state_q == ST_IDLE);
  wire isBusy       = (state_q == ST_BUSY);
  wire beginConv    = isIdle && convGo_q && startAllowed;
  wire finishConv   = isBusy && convDone;
  wire delayDone    = (delayCount_q == 3'h1);

  // ----------------------------------------------------------------
  // Repeat threshold
  // ----------------------------------------------------------------
  wire [7:0] countNext = triggerCount_q + 8'h01;
  wire thresholdHit = beginConv && (repeatThreshold_q != 8'h00)
                      && (countNext == repeatThreshold_q);

  always_comb begin
    triggerCount_d = triggerCount_q;
    if (thresholdHit) begin
      triggerCount_d = 8'h00;
    end else if (beginConv) begin
      triggerCount_d = countNext;
    end
  end

  // ----------------------------------------------------------------
  // Go bit
  // ----------------------------------------------------------------
  // Hardware sets beat the end-of-conversion clear so no trigger is
  // dropped when it lands on the completing cycle.
  always_comb begin
    convGo_d = convGo_q;
    if (swGoClear || (!convEnable_q && !wrCtrl0)) begin
      convGo_d = 1'b0;
    end
    if (finishConv && !continuousEnable_q) begin
      convGo_d = 1'b0;
    end
    if (swGoSet || hwTrigger) begin
      convGo_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d      = state_q;
    delayCount_d = delayCount_q;
    unique case (state_q)
      ST_IDLE: begin
        if (beginConv && convClockSelect_q) begin
          state_d      = ST_DELAY;
          delayCount_d = `INSTR_CYCLE_CLKS;
        end else if (beginConv) begin
          state_d = ST_START;
        end
      end
      ST_DELAY: begin
        delayCount_d = delayCount_q - 3'h1;
        if (delayDone) begin
          state_d = ST_START;
        end
      end
      ST_START: begin
        state_d = ST_BUSY;
      end
      ST_BUSY: begin
        if (convDone || !convEnable_q) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Status and sleep power handling
  // ----------------------------------------------------------------
  wire [`STAT_BITS-1:0] statusSet = {thresholdHit, finishConv};

  always_comb begin
    status_d = status_q;
    if (rdStatus) begin
      status_d = `STAT_BITS'(0);
    end
    status_d = status_d | statusSet;
  end

  // Masked completion in sleep drops analog power; the enable bit is
  // left alone so software sees the converter still enabled.
  always_comb begin
    powerDown_d = powerDown_q;
    if (!sleepActive) begin
      powerDown_d = 1'b0;
    end else if (finishConv && !mask_q[`STAT_DONE]) begin
      powerDown_d = 1'b1;
    end
  end

  wire [`STAT_BITS-1:0] pending = status_d & mask_q;
  wire irqNext  = |pending;
  wire wakeNext = sleepActive && finishConv
                  && mask_q[`STAT_DONE];

  // ----------------------------------------------------------------
  // Converter clock
  // ----------------------------------------------------------------
  logic divTick;
  wire  convRunning = !isIdle;

  clock_tick_divider divider_i (
    .clk     (clk),
    .reset   (reset),
    .clkEn   (clkEn),
    .run     (convRunning && !convClockSelect_q),
    .divider (clockDivider_q),
    .tick_q  (divTick)
  );

  wire clockTickNext = convRunning &&
                       (convClockSelect_q ? rcClockTick : divTick);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [15:0] resFmt  = formatResult(convResult_q, resultJustify_q);
  wire [15:0] prevFmt = formatResult(previousResult_q,
                                     resultJustify_q);
  wire [7:0]  ctrl0Read = {convEnable_q, continuousEnable_q, 1'b0,
                           convClockSelect_q, 1'b0, resultJustify_q,
                           1'b0, convGo_q};

  logic [7:0] rdMux;
  always_comb begin
    unique case (regAddr)
      `OFS_CTRL0:      rdMux = ctrl0Read;
      `OFS_EXTRA_CAP:  rdMux = {3'h0, extraSampleCap_q};
      `OFS_REPEAT_THR: rdMux = repeatThreshold_q;
      `OFS_TRIG_SEL:   rdMux = {3'h0, autoTrigSource_q};
      `OFS_CLK_DIV:    rdMux = {2'h0, clockDivider_q};
      `OFS_TRIG_COUNT: rdMux = triggerCount_q;
      `OFS_RESULT_HI:  rdMux = resFmt[15:8];
      `OFS_RESULT_LO:  rdMux = resFmt[7:0];
      `OFS_STATUS:     rdMux = {6'h00, status_q};
      `OFS_MASK:       rdMux = {6'h00, mask_q};
      `OFS_PREV_HI:    rdMux = prevFmt[15:8];
      `OFS_PREV_LO:    rdMux = prevFmt[7:0];
      default:         rdMux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      convEnable_q       <= 1'b0;
      continuousEnable_q <= 1'b0;
      convClockSelect_q  <= 1'b0;
      resultJustify_q    <= 1'b0;
    end else if (clkEn && wrCtrl0) begin
      convEnable_q       <= regWrData[`CTRL0_ENABLE];
      continuousEnable_q <= regWrData[`CTRL0_CONT];
      convClockSelect_q  <= regWrData[`CTRL0_CLKSEL];
      resultJustify_q    <= regWrData[`CTRL0_JUSTIFY];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      extraSampleCap_q  <= `SEL_WIDTH'(0);
      repeatThreshold_q <= `REG_RESET;
      autoTrigSource_q  <= `SEL_WIDTH'(0);
      clockDivider_q    <= `CLK_DIV_RESET;
      mask_q            <= `STAT_BITS'(0);
    end else if (clkEn) begin
      if (wrCap) begin
        extraSampleCap_q <= regWrData[`SEL_WIDTH-1:0];
      end
      if (wrRpt) begin
        repeatThreshold_q <= regWrData;
      end
      if (wrTrig) begin
        autoTrigSource_q <= regWrData[`SEL_WIDTH-1:0];
      end
      if (wrClkDiv) begin
        clockDivider_q <= regWrData[5:0];
      end
      if (wrMask) begin
        mask_q <= regWrData[`STAT_BITS-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      convGo_q       <= 1'b0;
      state_q        <= ST_IDLE;
      delayCount_q   <= 3'h0;
      triggerCount_q <= `REG_RESET;
      status_q       <= `STAT_BITS'(0);
      powerDown_q    <= 1'b0;
      autoPrev_q     <= 1'b0;
      extPrev_q      <= 1'b0;
    end else if (clkEn) begin
      convGo_q       <= convGo_d;
      state_q        <= state_d;
      delayCount_q   <= delayCount_d;
      triggerCount_q <= triggerCount_d;
      status_q       <= status_d;
      powerDown_q    <= powerDown_d;
      autoPrev_q     <= autoSelected;
      extPrev_q      <= extTrigger;
    end
  end

  // ----------------------------------------------------------------
  // Results
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      convResult_q     <= `RESULT_WIDTH'(0);
      previousResult_q <= `RESULT_WIDTH'(0);
    end else if (clkEn && finishConv) begin
      previousResult_q <= convResult_q;
      convResult_q     <= convData;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdData_q     <= 8'h00;
      convStart_q     <= 1'b0;
      convClockTick_q <= 1'b0;
      convPowered_q   <= 1'b0;
      wakeRequest_q   <= 1'b0;
      irq_q           <= 1'b0;
    end else if (clkEn) begin
      regRdData_q     <= regRd ? rdMux : 8'h00;
      convStart_q     <= (state_d == ST_START) && !(state_q == ST_START);
      convClockTick_q <= clockTickNext;
      convPowered_q   <= convEnable_q && !powerDown_d;
      wakeRequest_q   <= wakeNext;
      irq_q           <= irqNext;
    end
  end

endmodule : adc_conversion_control
`default_nettype wire

// ---- adc_conv_consts.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef ADC_CONV_CONSTS_SVH
`define ADC_CONV_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define OFS_CTRL0        4'h0
`define OFS_EXTRA_CAP    4'h1
`define OFS_REPEAT_THR   4'h2
`define OFS_TRIG_SEL     4'h3
`define OFS_CLK_DIV      4'h4
`define OFS_TRIG_COUNT   4'h5
`define OFS_RESULT_HI    4'h6
`define OFS_RESULT_LO    4'h7
`define OFS_STATUS       4'h8
`define OFS_MASK         4'h9
`define OFS_PREV_HI      4'hA
`define OFS_PREV_LO      4'hB

// ----------------------------------------------------------------
// Control register 0 fields
// ----------------------------------------------------------------
`define CTRL0_ENABLE     7
`define CTRL0_CONT       6
`define CTRL0_CLKSEL     4
`define CTRL0_JUSTIFY    2
`define CTRL0_GO         0
`define CTRL0_RW_MASK    8'hD5

// ----------------------------------------------------------------
// Status / mask fields
// ----------------------------------------------------------------
`define STAT_DONE        0
`define STAT_THRESHOLD   1
`define STAT_BITS        2

// ----------------------------------------------------------------
// Widths, reset values and timing
// ----------------------------------------------------------------
`define SEL_WIDTH        5
`define RESULT_WIDTH     10
`define REG_RESET        8'h00
`define CLK_DIV_RESET    6'h00
`define INSTR_CYCLE_CLKS 3'h4

`endif

// ---- adc_conv_pkg.sv ----
// Types shared by the converter control design
package adc_conv_pkg;

  // ----------------------------------------------------------------
  // Conversion sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_DELAY = 4'b0010,
    ST_START = 4'b0100,
    ST_BUSY  = 4'b1000
  } conv_state_e;

  typedef logic [7:0] reg_byte_t;

endpackage : adc_conv_pkg

// ---- clock_tick_divider.sv ----
// Divides the system clock into one-cycle converter clock ticks
`timescale 1ns/1ps
`default_nettype none
`include "adc_conv_consts.svh"

module clock_tick_divider
  import adc_conv_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clkEn,
  input  wire logic       run,
  input  wire logic [5:0] divider,
  output logic            tick_q
);

  logic [5:0] count_q;
  logic [5:0] count_d;
  logic       wrap;

  // ----------------------------------------------------------------
  // Tick every divider+1 clocks; held at zero while idle
  // ----------------------------------------------------------------
  assign wrap    = (count_q >= divider);
  assign count_d = (!run || wrap) ? 6'h00 : count_q + 6'h01;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q <= 6'h00;
      tick_q  <= 1'b0;
    end else if (clkEn) begin
      count_q <= count_d;
      tick_q  <= run && wrap;
    end
  end

endmodule : clock_tick_divider
`default_nettype wire

// ---- adc_conversion_control_asserts.sv ----
// Concurrent checks on the converter control ports
`timescale 1ns/1ps
`default_nettype none
`include "adc_conv_consts.svh"

module adc_conversion_control_asserts
  import adc_conv_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic [3:0]            regAddr,
  input wire logic [7:0]            regWrData,
  input wire logic                  regWr,
  input wire logic                  regRd,
  input wire logic                  sleepActive,
  input wire logic                  convDone,
  input wire logic                  convStart_q,
  input wire logic                  convPowered_q,
  input wire logic [`SEL_WIDTH-1:0] extraSampleCap_q,
  input wire logic                  wakeRequest_q,
  input wire logic                  irq_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_ctrl_wr(v);
    regWr && regAddr == `OFS_CTRL0 && regWrData == v;
  endsequence
  sequence s_status_rd;
    regRd && regAddr == `OFS_STATUS && !convDone ##1 !convDone;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_go_sys: assert property (
    s_ctrl_wr(8'h81) |-> !convStart_q[*2] ##1 convStart_q)
    else $error("system clock start not three cycles after go");
  // RC path waits one instruction cycle so a sleep can execute first
  chk_go_rc: assert property (
    s_ctrl_wr(8'h91) |-> !convStart_q[*6] ##1 convStart_q)
    else $error("RC clock start not delayed by one instruction");
  chk_start_once: assert property (
    convStart_q |=> !convStart_q)
    else $error("start pulse longer than one cycle");
  chk_cap_write: assert property (
    regWr && regAddr == `OFS_EXTRA_CAP
    |=> {3'h0, extraSampleCap_q} == ($past(regWrData) & 8'h1F))
    else $error("extra capacitance does not follow write");
  chk_off_write: assert property (
    regWr && regAddr == `OFS_CTRL0 && !regWrData[7]
    |-> ##2 !convPowered_q)
    else $error("converter powered after disable write");
  chk_wake_once: assert property (
    wakeRequest_q |=> !wakeRequest_q)
    else $error("wake pulse longer than one cycle");
  chk_wake_cause: assert property (
    wakeRequest_q |-> $past(sleepActive)
      && ($past(convDone) || $past(convDone, 2)))
    else $error("wake without completion in sleep");
  chk_irq_clear: assert property (
    s_status_rd |=> !irq_q)
    else $error("interrupt stays high after status read");
  chk_power_down: assert property (
    $fell(convPowered_q) |-> $past(sleepActive) || $past(regWr, 2))
    else $error("power dropped without sleep or write");

endmodule : adc_conversion_control_asserts
`default_nettype wire

// ---- tb_adc_conversion_control.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "adc_conv_consts.svh"

module tb_adc_conversion_control
  import adc_conv_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        clkEn = 1'b1;
  logic [3:0]  regAddr = 4'h0;
  reg_byte_t   regWrData = 8'h00;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  reg_byte_t   regRdData_q;
  logic        sleepActive = 1'b0;
  logic        extTrigger = 1'b0;
  logic [31:0] autoTrigSources = 32'h0;
  logic        rcClockTick = 1'b0;
  logic        convDone = 1'b0;
  logic [9:0]  convData = 10'h000;
  logic        convStart_q, convClockTick_q, convPowered_q;
  logic        wakeRequest_q, irq_q;
  logic [4:0]  extraSampleCap_q;
  logic [31:0] rngState = 32'h459FA66B;
  int          nMismatch = 0, cmpCount = 0, cycles = 0;
  int          startCnt = 0, wakeCnt = 0, tickCnt = 0, s, w, k;
  reg_byte_t   v;
  logic [9:0]  d;
  logic [4:0]  sel;
  logic [3:0]  addrTab [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'h5, 4'hE};
  reg_byte_t   maskTab [7] = '{8'h1F, 8'hFF, 8'h1F, 8'h3F, 8'h03, 8'h00,
                               8'h00};

  adc_conversion_control u_dut (
    .clk(clk), .reset(reset), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData_q(regRdData_q), .sleepActive(sleepActive),
    .extTrigger(extTrigger), .autoTrigSources(autoTrigSources),
    .rcClockTick(rcClockTick), .convDone(convDone), .convData(convData),
    .convStart_q(convStart_q), .convClockTick_q(convClockTick_q),
    .convPowered_q(convPowered_q), .extraSampleCap_q(extraSampleCap_q),
    .wakeRequest_q(wakeRequest_q), .irq_q(irq_q)
  );

  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rngState = rngState ^ (rngState << 13);
    rngState = rngState ^ (rngState >> 17);
    rngState = rngState ^ (rngState << 5);
    return rngState;
  endfunction : rnd
  function automatic reg_byte_t resHi(logic [9:0] x, logic j);
    return j ? {6'h00, x[9:8]} : x[9:2];
  endfunction : resHi
  function automatic reg_byte_t resLo(logic [9:0] x, logic j);
    return j ? x[7:0] : {x[1:0], 6'h00};
  endfunction : resLo

  task automatic chk(input reg_byte_t seen, input reg_byte_t exp);
    cmpCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // A free edge after each strobe keeps back-to-back calls race-free
  task automatic wr(input logic [3:0] a, input reg_byte_t x);
    regAddr <= a;
    regWrData <= x;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rdChk(input logic [3:0] a, input reg_byte_t x);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    v = regRdData_q;
    chk(v, x);
  endtask : rdChk
  // Plays the analog core: waits for a start, then reports completion
  task automatic convert(input logic [31:0] x);
    int n;
    n = 0;
    while (convStart_q !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk({7'h0, convStart_q}, 8'h01);
    repeat (3) @(posedge clk);
    convData <= x[9:0];
    convDone <= 1'b1;
    @(posedge clk);
    convDone <= 1'b0;
  endtask : convert
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles++;
    if (convStart_q === 1'b1) startCnt++;
    if (wakeRequest_q === 1'b1) wakeCnt++;
    if (convClockTick_q === 1'b1) tickCnt++;
    rcClockTick <= ^rnd();
    if (cycles == 20000) begin
      nMismatch++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 16; a++) rdChk(a[3:0], 8'h00);
    for (int i = 0; i < 21; i++) begin
      v = (i == 0) ? 8'hFF : (i == 7) ? 8'h00 : 8'(rnd());
      wr(addrTab[i % 7], v);
      rdChk(addrTab[i % 7], v & maskTab[i % 7]);
      if (i % 7 == 0) chk({3'h0, extraSampleCap_q}, v & 8'h1F);
    end
    wr(`OFS_REPEAT_THR, 8'h03);
    wr(`OFS_MASK, 8'h03);
    for (int j = 0; j < 2; j++) begin
      d = 10'(rnd());
      wr(`OFS_CTRL0, j ? 8'h85 : 8'h81);
      convert({22'h0, d});
      repeat (2) @(posedge clk);
      chk({7'h0, irq_q}, 8'h01);
      rdChk(`OFS_STATUS, 8'h01);
      rdChk(`OFS_RESULT_HI, resHi(d, j[0]));
      rdChk(`OFS_RESULT_LO, resLo(d, j[0]));
      rdChk(`OFS_CTRL0, j ? 8'h84 : 8'h80);
    end
    rdChk(`OFS_TRIG_COUNT, 8'h02);
    d = 10'(rnd());
    wr(`OFS_CTRL0, 8'h91);
    convert({22'h0, d});
    repeat (2) @(posedge clk);
    rdChk(`OFS_STATUS, 8'h03);
    rdChk(`OFS_TRIG_COUNT, 8'h00);
    rdChk(`OFS_RESULT_HI, resHi(d, 1'b0));
    rdChk(`OFS_CTRL0, 8'h90);
    wr(`OFS_CTRL0, 8'hC1);
    convert(rnd());
    convert(rnd());
    rdChk(`OFS_CTRL0, 8'hC1);
    wr(`OFS_CTRL0, 8'h00);
    // Power follows the enable register, so it drops one edge later
    @(posedge clk);
    chk({7'h0, convPowered_q}, 8'h00);
    rdChk(`OFS_CTRL0, 8'h00);
    for (int t = 0; t < 4; t++) begin
      sel = (t == 0) ? 5'h00 : (t == 1) ? 5'h1F : 5'(rnd());
      wr(`OFS_TRIG_SEL, {3'h0, sel});
      wr(`OFS_CTRL0, 8'h80);
      s = startCnt;
      k = tickCnt;
      autoTrigSources <= 32'h1 << (sel + 5'h01);
      repeat (12) @(posedge clk);
      chk(s[7:0], startCnt[7:0]);
      chk(tickCnt[7:0], k[7:0]);
      autoTrigSources <= 32'h1 << sel;
      convert(rnd());
      autoTrigSources <= 32'h0;
      repeat (2) @(posedge clk);
      rdChk(`OFS_CTRL0, 8'h80);
    end
    wr(`OFS_MASK, 8'h01);
    sleepActive <= 1'b1;
    extTrigger <= 1'b1;
    s = startCnt;
    repeat (20) @(posedge clk);
    chk(s[7:0], startCnt[7:0]);
    sleepActive <= 1'b0;
    convert(rnd());
    extTrigger <= 1'b0;
    wr(`OFS_CTRL0, 8'h90);
    rdChk(`OFS_STATUS, 8'h03);
    w = wakeCnt;
    sleepActive <= 1'b1;
    extTrigger <= 1'b1;
    convert(rnd());
    repeat (3) @(posedge clk);
    chk(wakeCnt[7:0], w[7:0] + 8'h01);
    rdChk(`OFS_STATUS, 8'h03);
    extTrigger <= 1'b0;
    wr(`OFS_MASK, 8'h00);
    extTrigger <= 1'b1;
    convert(rnd());
    repeat (3) @(posedge clk);
    chk(wakeCnt[7:0], w[7:0] + 8'h01);
    chk({7'h0, convPowered_q}, 8'h00);
    rdChk(`OFS_CTRL0, 8'h90);
    sleepActive <= 1'b0;
    repeat (3) @(posedge clk);
    chk({7'h0, convPowered_q}, 8'h01);
    // A write while the clock enable is low must be dropped
    clkEn <= 1'b0;
    wr(`OFS_REPEAT_THR, 8'h5A);
    clkEn <= 1'b1;
    rdChk(`OFS_REPEAT_THR, 8'h03);
    complete_run();
  end

endmodule : tb_adc_conversion_control

bind adc_conversion_control adc_conversion_control_asserts u_chk (
  .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .sleepActive(sleepActive),
  .convDone(convDone), .convStart_q(convStart_q),
  .convPowered_q(convPowered_q), .extraSampleCap_q(extraSampleCap_q),
  .wakeRequest_q(wakeRequest_q), .irq_q(irq_q)
);
`default_nettype wire
